// >>> logic/ajt_axis_jog.sv
// Per-axis manual jog control: key evaluation, increment tracking, feedback
//
// Functional notes
// - Edge-triggered continuous jog starts on a key rise, keeps going after release, stops on the next rise of the same key.
// - Level-triggered incremental jog moves while the key is 1 and pauses if it drops before the end.
// - A paused level-triggered increment resumes when the key returns to 1, as often as needed.
// - Edge-triggered incremental jog starts on a rise; a second rise of the same key cancels it.
// - Plus and minus together give no motion and abort any motion in progress.
// - The per-axis key disable makes the axis ignore its traverse keys.
// - Keys are ignored in automatic and manual data entry modes.
// - An axis already moved as a geometry axis is refused and the alarm 20062 is raised.
// - Exactly one increment is moved per key actuation.
// - Fixed step sizes come from the increment table, the variable step from its own setting.
// - The active function is reported in a feedback byte.
// - More than one select bit set activates no incremental function; with the continuous bit 6 and one step bit set, that step increment still runs.
// - Setting or changing a step select bit 0 to 5 during an increment cancels it; setting the continuous bit 6 does not.
// - Level-triggered continuous jog moves only while the key is 1 and stops at a limit.
// - Level or edge key behaviour is chosen separately for continuous and incremental jog.
`timescale 1ns/10ps
`include "ajt_params.svh"
module ajt_axis_jog
    import ajt_pkg::*;
#(
    parameter int POS_W = 32
)
(
    input  wire logic              sys_clk_i,
    input  wire logic              sys_rst_i,
    input  wire logic              key_plus_i,
    input  wire logic              key_minus_i,
    input  wire logic              traverse_key_disable_i,
    input  wire logic              auto_mode_i,
    input  wire logic              manual_data_entry_mode_i,
    input  wire logic              geo_axis_active_i,
    input  wire logic [7:0]        increment_step_select_i,
    input  wire logic              cont_level_triggered_i,
    input  wire logic              inc_level_triggered_i,
    input  wire logic [POS_W-1:0]  increment_size_table_i [5],
    input  wire logic [POS_W-1:0]  variable_increment_size_i,
    input  wire logic              limit_reached_i,
    input  wire logic              step_done_i,
    output logic                   move_en_o,
    output logic                   move_dir_minus_o,
    output logic [POS_W-1:0]       remaining_o,
    output logic [7:0]             active_function_feedback_o,
    output logic                   alarm_o,
    output logic [15:0]            alarm_code_o
);

    // Elaboration-time refusal of widths the counters cannot serve
    if (POS_W < 16)
    begin
        $error("POS_W too small");
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef enum logic [3:0]
    {
        ST_IDLE   = 4'h1,
        ST_CONT   = 4'h2,
        ST_INC    = 4'h4,
        ST_PAUSE  = 4'h8
    } ajt_state_type;

    ajt_state_type      state;
    ajt_state_type      next_state;
    ajt_dir_type        dir;
    ajt_dir_type        next_dir;
    logic [POS_W-1:0]   remaining;
    logic [POS_W-1:0]   next_remaining;
    logic [5:0]         prev_sel;
    ajt_keys_type       keys;
    ajt_edges_type      edges;

    function automatic logic one_hot6(input logic [5:0] v);
        return (v != 6'h00) && ((v & (v - 6'h01)) == 6'h00);
    endfunction

    // ----------------------------------------------------------------
    // Key gating and edges
    // ----------------------------------------------------------------
    wire keys_blocked = traverse_key_disable_i | auto_mode_i | manual_data_entry_mode_i;
    wire geo_refuse   = geo_axis_active_i & (key_plus_i | key_minus_i) & ~keys_blocked;
    wire keys_ok      = ~keys_blocked & ~geo_axis_active_i;
    assign keys.plus  = keys_ok & key_plus_i;
    assign keys.minus = keys_ok & key_minus_i;

    ajt_key_edge u_key_edge
    (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .keys_i    (keys),
        .edges_o   (edges)
    );

    // ----------------------------------------------------------------
    // Function decode
    // ----------------------------------------------------------------
    wire [5:0] step_sel   = increment_step_select_i[`AJT_STEP_SEL_MSB:`AJT_STEP_SEL_LSB];
    wire       step_valid = one_hot6(step_sel);
    wire       cont_sel   = increment_step_select_i[`AJT_SEL_CONTINUOUS];
    wire       cont_valid = cont_sel & (step_sel == 6'h00);
    wire       sel_change = (step_sel != prev_sel) & (step_sel != 6'h00);
    wire       both_keys  = keys.plus & keys.minus;

    // Fixed steps index the table, the variable step has its own setting
    logic [POS_W-1:0] step_size;
    always_comb
    begin
        step_size = variable_increment_size_i;
        for (int i = 0; i < 5; i++)
        begin
            if (step_sel[i])
                step_size = increment_size_table_i[i];
        end
    end

    wire         key_rise  = edges.rise_plus | edges.rise_minus;
    ajt_dir_type rise_dir;
    assign rise_dir = edges.rise_plus ? AJT_DIR_PLUS : AJT_DIR_MINUS;
    wire         same_rise = (dir == AJT_DIR_PLUS) ? edges.rise_plus : edges.rise_minus;
    wire         dir_key   = (dir == AJT_DIR_PLUS) ? keys.plus : keys.minus;

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb
    begin
        next_state     = state;
        next_dir       = dir;
        next_remaining = remaining;
        case (state)
            ST_IDLE:
            begin
                // No start while a position limit is active, else level jog restarts into it
                if (!both_keys && !limit_reached_i && cont_valid)
                begin
                    if (cont_level_triggered_i && (keys.plus ^ keys.minus))
                    begin
                        next_state = ST_CONT;
                        next_dir   = keys.plus ? AJT_DIR_PLUS : AJT_DIR_MINUS;
                    end
                    else if (!cont_level_triggered_i && key_rise)
                    begin
                        next_state = ST_CONT;
                        next_dir   = rise_dir;
                    end
                end
                else if (!both_keys && !limit_reached_i && step_valid && key_rise)
                begin
                    next_state     = ST_INC;
                    next_dir       = rise_dir;
                    next_remaining = step_size;
                end
            end
            ST_CONT:
            begin
                if (both_keys || !cont_valid || limit_reached_i)
                    next_state = ST_IDLE;
                else if (cont_level_triggered_i && !dir_key)
                    next_state = ST_IDLE;
                else if (!cont_level_triggered_i && same_rise)
                    next_state = ST_IDLE;
            end
            ST_INC, ST_PAUSE:
            begin
                // A unit reported on the pausing edge was still travelled, so it is counted first
                if (state == ST_INC && step_done_i)
                    next_remaining = remaining - POS_W'(1);
                if (both_keys || sel_change || !step_valid || limit_reached_i)
                begin
                    next_state     = ST_IDLE;
                    next_remaining = '0;
                end
                else if (!inc_level_triggered_i && same_rise)
                begin
                    next_state     = ST_IDLE;
                    next_remaining = '0;
                end
                else if (state == ST_INC && step_done_i && remaining == POS_W'(1))
                    next_state = ST_IDLE;
                else if (inc_level_triggered_i && !dir_key)
                    next_state = ST_PAUSE;
                else
                    next_state = ST_INC;
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            state     <= ST_IDLE;
            dir       <= AJT_DIR_NONE;
            remaining <= '0;
            prev_sel  <= '0;
        end
        else
        begin
            state     <= next_state;
            dir       <= next_dir;
            remaining <= next_remaining;
            prev_sel  <= step_sel;
        end
    end

    // Outputs registered from the next values so they line up with state
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            move_en_o                  <= 1'b0;
            move_dir_minus_o           <= 1'b0;
            remaining_o                <= '0;
            active_function_feedback_o <= `AJT_FEEDBACK_RESET;
            alarm_o                    <= 1'b0;
            alarm_code_o               <= 16'h0000;
        end
        else
        begin
            move_en_o                  <= (next_state == ST_CONT) || (next_state == ST_INC);
            move_dir_minus_o           <= (next_dir == AJT_DIR_MINUS);
            remaining_o                <= next_remaining;
            active_function_feedback_o <= {1'b0, cont_valid, step_valid ? step_sel : 6'h00};
            alarm_o                    <= geo_refuse;
            alarm_code_o               <= geo_refuse ? `AJT_ALARM_GEO_BUSY : 16'h0000;
        end
    end

endmodule

// >>> logic/ajt_key_edge.sv
// Edge detector for the plus and minus traverse keys
`timescale 1ns/10ps
module ajt_key_edge
    import ajt_pkg::*;
(
    input  wire logic          sys_clk_i,
    input  wire logic          sys_rst_i,
    input  wire ajt_keys_type  keys_i,
    output ajt_edges_type      edges_o
);

    ajt_keys_type prev_keys;

    // ----------------------------------------------------------------
    // Previous-cycle sample
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
            prev_keys <= '0;
        else
            prev_keys <= keys_i;
    end

    assign edges_o.rise_plus  = keys_i.plus & ~prev_keys.plus;
    assign edges_o.rise_minus = keys_i.minus & ~prev_keys.minus;
    assign edges_o.fall_plus  = ~keys_i.plus & prev_keys.plus;
    assign edges_o.fall_minus = ~keys_i.minus & prev_keys.minus;

endmodule

// >>> logic/ajt_params.svh
// Constants for the axis jog traverse control block
`ifndef AJT_PARAMS_SVH
`define AJT_PARAMS_SVH

// ----------------------------------------------------------------
// Select byte field positions
// ----------------------------------------------------------------
`define AJT_SEL_STEP_ONE          0
`define AJT_SEL_STEP_TEN          1
`define AJT_SEL_STEP_HUNDRED      2
`define AJT_SEL_STEP_THOUSAND     3
`define AJT_SEL_STEP_TEN_THOUSAND 4
`define AJT_SEL_STEP_VARIABLE     5
`define AJT_SEL_CONTINUOUS        6
`define AJT_STEP_SEL_LSB          0
`define AJT_STEP_SEL_MSB          5

// ----------------------------------------------------------------
// Reset values and alarm code
// ----------------------------------------------------------------
`define AJT_SELECT_RESET          8'h00
`define AJT_FEEDBACK_RESET        8'h00
`define AJT_ALARM_GEO_BUSY        16'd20062

`endif

// >>> logic/ajt_pkg.sv
// Types shared by the axis jog traverse control block
package ajt_pkg;

    typedef enum logic [1:0]
    {
        AJT_DIR_NONE = 2'h0,
        AJT_DIR_PLUS = 2'h1,
        AJT_DIR_MINUS = 2'h2
    } ajt_dir_type;

    typedef struct packed
    {
        logic plus;
        logic minus;
    } ajt_keys_type;

    typedef struct packed
    {
        logic rise_plus;
        logic rise_minus;
        logic fall_plus;
        logic fall_minus;
    } ajt_edges_type;

endpackage

// >>> sim/ajt_axis_jog_props.sv
// Concurrent checks on the ports of the axis jog block
`timescale 1ns/10ps
module ajt_axis_jog_props
#(
    parameter int POS_W = 32
)
(
    input wire logic             sys_clk_i,
    input wire logic             sys_rst_i,
    input wire logic             key_plus_i,
    input wire logic             key_minus_i,
    input wire logic             traverse_key_disable_i,
    input wire logic             auto_mode_i,
    input wire logic             manual_data_entry_mode_i,
    input wire logic             geo_axis_active_i,
    input wire logic [7:0]       increment_step_select_i,
    input wire logic             inc_level_triggered_i,
    input wire logic [POS_W-1:0] increment_size_table_i [5],
    input wire logic             limit_reached_i,
    input wire logic             step_done_i,
    input wire logic             move_en_o,
    input wire logic             move_dir_minus_o,
    input wire logic [POS_W-1:0] remaining_o,
    input wire logic [7:0]       active_function_feedback_o,
    input wire logic             alarm_o,
    input wire logic [15:0]      alarm_code_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    wire gate = traverse_key_disable_i | auto_mode_i | manual_data_entry_mode_i;
    wire idle = !move_en_o && remaining_o == '0;
    sequence edge_start;
        !inc_level_triggered_i && increment_step_select_i == 8'h01 && !gate && !geo_axis_active_i && idle
            && $stable(increment_step_select_i) && $rose(key_plus_i) && !key_minus_i && !limit_reached_i;
    endsequence
    sequence level_release;
        inc_level_triggered_i && move_en_o && remaining_o != '0 && !key_plus_i && !key_minus_i
            && $stable(increment_step_select_i) && !limit_reached_i;
    endsequence
    inc_start_a: assert property (edge_start |=> move_en_o && !move_dir_minus_o
        && remaining_o == increment_size_table_i[0]) else $error("increment did not start");
    level_pause_a: assert property (level_release |=> !move_en_o
        && remaining_o == $past(remaining_o) - POS_W'($past(step_done_i))) else $error("increment did not pause");
    both_keys_a: assert property (key_plus_i && key_minus_i |=> !move_en_o)
        else $error("motion with both keys");
    gate_ignore_a: assert property (gate && idle |=> !move_en_o)
        else $error("keys not ignored");
    geo_alarm_a: assert property (geo_axis_active_i && (key_plus_i || key_minus_i) && !gate && idle
        |=> alarm_o && alarm_code_o == 16'h4e5e && !move_en_o) else $error("geometry refusal wrong");
    alarm_code_a: assert property (!alarm_o |-> alarm_code_o == 16'h0000)
        else $error("alarm code without alarm");
    multi_sel_a: assert property ($countones(increment_step_select_i[5:0]) > 1
        |=> active_function_feedback_o == 8'h00) else $error("function active with several selects");
    one_sel_a: assert property ($onehot(increment_step_select_i[5:0])
        |=> active_function_feedback_o == {2'b00, $past(increment_step_select_i[5:0])}) else $error("feedback wrong");
    sel_cancel_a: assert property ($changed(increment_step_select_i[5:0]) && remaining_o != '0
        |=> idle) else $error("select change did not cancel");
    limit_stop_a: assert property (limit_reached_i |=> !move_en_o)
        else $error("moving at limit");
endmodule
bind ajt_axis_jog ajt_axis_jog_props #(.POS_W(POS_W)) u_props (.sys_clk_i, .sys_rst_i, .key_plus_i, .key_minus_i,
    .traverse_key_disable_i, .auto_mode_i, .manual_data_entry_mode_i, .geo_axis_active_i, .increment_step_select_i,
    .inc_level_triggered_i, .increment_size_table_i, .limit_reached_i, .move_en_o, .move_dir_minus_o, .remaining_o,
    .active_function_feedback_o, .alarm_o, .alarm_code_o, .step_done_i);

// >>> sim/ajt_motion_model.sv
// Behavioural motion stage that reports covered units back to the jog block
`timescale 1ns/10ps
module ajt_motion_model
(
    input  wire logic       sys_clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       move_en_i,
    input  wire logic [1:0] gap_i,
    output logic            step_done_o
);
    logic [1:0] cnt;
    // Combinational so no unit is ever reported after the axis stopped
    assign step_done_o = move_en_i && cnt == gap_i;
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i || !move_en_i || cnt == gap_i)
            cnt <= 2'h0;
        else
            cnt <= cnt + 2'h1;
    end
endmodule

// >>> sim/testbench.sv
// Self-checking bench for the axis jog traverse control block
`timescale 1ns/10ps
module testbench;
    logic        sys_clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        kp = 0, km = 0, dis = 0, aut = 0, mde = 0, geo = 0, clv = 0, ilv = 0, lim = 0;
    logic [1:0]  gap = 2'h0;
    logic [7:0]  sel = 8'h00;
    logic [31:0] tbl [5] = '{32'h3, 32'h4, 32'h6, 32'h7, 32'h8};
    logic [31:0] rem, held;
    logic [7:0]  fb;
    logic [15:0] acode;
    logic        men, mdir, alm, step;
    int          err_count = 0, checked = 0, cyc = 0;
    initial forever #4 sys_clk_i = ~sys_clk_i;
    ajt_axis_jog u_dut (.sys_clk_i, .sys_rst_i, .key_plus_i(kp), .key_minus_i(km), .traverse_key_disable_i(dis),
        .auto_mode_i(aut), .manual_data_entry_mode_i(mde), .geo_axis_active_i(geo), .increment_step_select_i(sel),
        .cont_level_triggered_i(clv), .inc_level_triggered_i(ilv), .increment_size_table_i(tbl),
        .variable_increment_size_i(32'h5), .limit_reached_i(lim), .step_done_i(step), .move_en_o(men),
        .move_dir_minus_o(mdir), .remaining_o(rem), .active_function_feedback_o(fb), .alarm_o(alm),
        .alarm_code_o(acode));
    ajt_motion_model u_motion (.sys_clk_i, .sys_rst_i, .move_en_i(men), .gap_i(gap), .step_done_o(step));
    // Wide enough for a full remaining count joined with a flag bit
    task chk(input string nm, input logic [39:0] exp, input logic [39:0] got);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Lets one sampling edge pass, then looks once outputs have settled
    task look;
        @(posedge sys_clk_i);
        @(negedge sys_clk_i);
    endtask
    task press(input logic p, input logic m);
        @(posedge sys_clk_i) {kp, km} <= {p, m};
        @(posedge sys_clk_i) {kp, km} <= 2'b00;
        @(negedge sys_clk_i);
    endtask
    task wait_idle;
        for (int i = 0; i < 300 && men !== 1'b0; i++)
            @(negedge sys_clk_i);
        chk("idle", 32'h0, men);
    endtask
    always @(posedge sys_clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_count++;
            tally_and_finish;
        end
    end
    initial
    begin
        repeat (12) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        look;
        chk("reset", 32'h0, {men, alm, fb, rem[7:0]});
        @(posedge sys_clk_i) sel <= 8'h01;
        press(1, 0);
        chk("inc_len", 32'h3, rem);
        wait_idle;
        @(posedge sys_clk_i) {gap, sel} <= {2'h3, 8'h20};
        press(0, 1);
        chk("var_len", {32'h5, 1'b1}, {rem, mdir});
        press(0, 1);
        chk("edge_cancel", 32'h0, {men, rem});
        @(posedge sys_clk_i) {ilv, sel, km} <= {1'b1, 8'h02, 1'b1};
        repeat (3) look;
        chk("lvl_run", 32'h1, men);
        @(posedge sys_clk_i) km <= 1'b0;
        look;
        held = rem;
        repeat (3) look;
        chk("lvl_pause", {held, 1'b0}, {rem, men});
        @(posedge sys_clk_i) km <= 1'b1;
        look;
        chk("lvl_resume", 32'h1, men);
        wait_idle;
        repeat (3) look;
        chk("one_per_press", 32'h0, {men, rem});
        @(posedge sys_clk_i) {ilv, km, sel} <= {2'b00, 8'h01};
        press(1, 0);
        @(posedge sys_clk_i) sel <= 8'h04;
        look;
        chk("sel_cancel", 32'h0, {men, rem});
        @(posedge sys_clk_i) sel <= 8'h03;
        press(1, 0);
        chk("multi_sel", 32'h0, {men, fb});
        for (int i = 0; i < 7; i++)
        begin
            @(posedge sys_clk_i) sel <= 8'h01 << i;
            look;
            chk("feedback", 32'h1 << i, fb);
        end
        @(posedge sys_clk_i) gap <= 2'h0;
        press(1, 0);
        repeat (10) look;
        chk("cont_keep", {1'b1, 32'h0}, {men, rem});
        press(1, 0);
        chk("cont_stop", 32'h0, men);
        press(0, 1);
        press(1, 1);
        chk("both_keys", 32'h0, men);
        for (int g = 0; g < 3; g++)
        begin
            @(posedge sys_clk_i) {dis, aut, mde} <= 3'b001 << g;
            press(1, 0);
            chk("gated", 32'h0, men);
            @(posedge sys_clk_i) {dis, aut, mde} <= 3'b000;
        end
        @(posedge sys_clk_i) {geo, kp} <= 2'b11;
        look;
        chk("geo_alarm", {16'h4e5e, 2'b10}, {acode, alm, men});
        @(posedge sys_clk_i) {geo, kp, clv} <= 3'b001;
        look;
        chk("alarm_clear", 32'h0, {acode, alm});
        @(posedge sys_clk_i) kp <= 1'b1;
        look;
        chk("lvl_cont", 32'h1, men);
        @(posedge sys_clk_i) kp <= 1'b0;
        look;
        chk("lvl_cont_stop", 32'h0, men);
        @(posedge sys_clk_i) kp <= 1'b1;
        look;
        @(posedge sys_clk_i) lim <= 1'b1;
        look;
        chk("limit_stop", 32'h0, men);
        look;
        chk("limit_hold", 32'h0, men);
        tally_and_finish;
    end
endmodule
